// ---- rtl/trim_bank_regs.svh ----
// Register offsets, field positions, reset values and load timing of the trim bank.
`ifndef TRIM_BANK_REGS_SVH
`define TRIM_BANK_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the configuration port
// ----------------------------------------------------------------------------
`define OFFSET_TRIM_CORE3_INPUT_C_ADDR    12'h338
`define OFFSET_TRIM_CORE3_INPUT_D_ADDR    12'h33A
`define OFFSET_TRIM_CORE4_ADDR            12'h33C
`define OFFSET_TRIM_CORE5_ADDR            12'h33E
`define FINE_GAIN_TRIM_CORE0_ADDR         12'h360
`define FINE_GAIN_TRIM_CORE1_ADDR         12'h361
`define FINE_GAIN_TRIM_CORE2_INPUT_A_ADDR 12'h362
`define FINE_GAIN_TRIM_CORE2_INPUT_B_ADDR 12'h363
`define FINE_GAIN_TRIM_CORE3_INPUT_C_ADDR 12'h364
`define FINE_GAIN_TRIM_CORE3_INPUT_D_ADDR 12'h365
`define FINE_GAIN_TRIM_CORE4_ADDR         12'h366
`define FINE_GAIN_TRIM_CORE5_ADDR         12'h367

// ----------------------------------------------------------------------------
// Storage slots, one per register, also the fuse word index
// ----------------------------------------------------------------------------
`define IDX_OFFSET_TRIM_CORE3_INPUT_C  4'h0
`define IDX_OFFSET_TRIM_CORE3_INPUT_D  4'h1
`define IDX_OFFSET_TRIM_CORE4   4'h2
`define IDX_OFFSET_TRIM_CORE5   4'h3
`define IDX_FINE_GAIN_TRIM_CORE0  4'h4
`define IDX_FINE_GAIN_TRIM_CORE1  4'h5
`define IDX_FINE_GAIN_TRIM_CORE2_INPUT_A 4'h6
`define IDX_FINE_GAIN_TRIM_CORE2_INPUT_B 4'h7
`define IDX_FINE_GAIN_TRIM_CORE3_INPUT_C 4'h8
`define IDX_FINE_GAIN_TRIM_CORE3_INPUT_D 4'h9
`define IDX_FINE_GAIN_TRIM_CORE4  4'hA
`define IDX_FINE_GAIN_TRIM_CORE5  4'hB
`define IDX_LAST   4'hB
`define NUM_TRIM   12

// ----------------------------------------------------------------------------
// Fields, masks, reset values and timing
// ----------------------------------------------------------------------------
`define OFS_FIELD_MSB  11
`define GAIN_FIELD_MSB 4
`define OFS_REG_MASK   16'hFFFF
`define GAIN_REG_MASK  16'h00FF
`define TRIM_RESET     16'h0000
`define LOAD_CYCLES    13

`endif

// ---- rtl/trim_bank_pkg.sv ----
// Types shared by the trim bank modules.
package trim_bank_pkg;
    typedef enum logic [1:0] {LOAD, LAST, RUN} load_state_t;
    typedef logic [15:0]     trim_word_t;
    typedef logic [3:0]      trim_idx_t;
endpackage : trim_bank_pkg

// ---- rtl/fuse_if.sv ----
// Read path between the trim bank and its fuse image store.
`timescale 1ns/1ps
`default_nettype none
interface fuse_if;
    logic        rd_en;
    logic [3:0]  addr;
    logic [15:0] data;
    modport reader (output rd_en, output addr, input data);
    modport store  (input rd_en, input addr, output data);
endinterface : fuse_if
`default_nettype wire

// ---- rtl/trim_fuse_store.sv ----
// Factory fuse image of the trim defaults, read one word per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "trim_bank_regs.svh"
module trim_fuse_store
    import trim_bank_pkg::*;
#(
    // Packed image, word i in bits 16*i+15 down to 16*i; programmed per part.
    parameter logic [16*`NUM_TRIM-1:0] FUSE_IMAGE = '0
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Read port
    fuse_if.store     fuse
);
    // Read data come out of a register, one cycle after the request.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fuse.data <= `TRIM_RESET;
        end else if (fuse.rd_en && (fuse.addr <= `IDX_LAST)) begin
            fuse.data <= FUSE_IMAGE[fuse.addr*16 +: 16];
        end
    end
endmodule : trim_fuse_store
`default_nettype wire

// ---- rtl/converter_offset_gain_trim_bank.sv ----
// Offset and fine gain trim registers for the converter cores, with fuse defaults.
//
// Operation
// - Core 3 input C uses its offset trim.
// - Core 3 input D uses separate offset trim.
// - Cores 4 and 5 get own offsets.
// - Cores 0,1,4,5 get 5-bit gain trims.
// - Core 2 gain follows its selected input.
// - Core 3 gain follows its selected input.
// - Offset trims load defaults from fuses.
// - Gain trims load defaults from fuses.
// - Decode offsets 0x338-0x33E, gains 0x360-0x367.
// - Offset trims are unsigned values.
`timescale 1ns/1ps
`default_nettype none
`include "trim_bank_regs.svh"
module converter_offset_gain_trim_bank
    import trim_bank_pkg::*;
#(
    parameter int                       ADDR_W     = 12,
    parameter int                       DATA_W     = 16,
    parameter logic [16*`NUM_TRIM-1:0]  FUSE_IMAGE = '0
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // Configuration port
    input  wire logic [ADDR_W-1:0] cfg_addr,
    input  wire logic [DATA_W-1:0] cfg_wdata,
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    output logic      [DATA_W-1:0] cfg_rdata,
    // Input mux selects, 0 for the first input, 1 for the second
    input  wire logic              core2_input_sel,
    input  wire logic              core3_input_sel,
    // Selects as applied, aligned with the trims below
    output logic                   core2_input_sel_applied,
    output logic                   core3_input_sel_applied,
    // Offset trims to the cores, unsigned
    output logic      [11:0]       offset_core3,
    output logic      [11:0]       offset_core4,
    output logic      [11:0]       offset_core5,
    // Fine gain trims to the cores
    output logic      [4:0]        gain_core0,
    output logic      [4:0]        gain_core1,
    output logic      [4:0]        gain_core2,
    output logic      [4:0]        gain_core3,
    output logic      [4:0]        gain_core4,
    output logic      [4:0]        gain_core5,
    // Fuse defaults loaded
    output logic                   load_done
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (ADDR_W < 10 || DATA_W != 16) begin : g_bad_param
        $error("trim bank needs ADDR_W >= 10 and DATA_W == 16");
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Maps a port address to {hit, slot}; reads and writes share it.
    function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
        logic [4:0] r;
        r = 5'h00;
        case (a)
            ADDR_W'(`OFFSET_TRIM_CORE3_INPUT_C_ADDR):    r = {1'b1, `IDX_OFFSET_TRIM_CORE3_INPUT_C};
            ADDR_W'(`OFFSET_TRIM_CORE3_INPUT_D_ADDR):    r = {1'b1, `IDX_OFFSET_TRIM_CORE3_INPUT_D};
            ADDR_W'(`OFFSET_TRIM_CORE4_ADDR):            r = {1'b1, `IDX_OFFSET_TRIM_CORE4};
            ADDR_W'(`OFFSET_TRIM_CORE5_ADDR):            r = {1'b1, `IDX_OFFSET_TRIM_CORE5};
            ADDR_W'(`FINE_GAIN_TRIM_CORE0_ADDR):         r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE0};
            ADDR_W'(`FINE_GAIN_TRIM_CORE1_ADDR):         r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE1};
            ADDR_W'(`FINE_GAIN_TRIM_CORE2_INPUT_A_ADDR): r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE2_INPUT_A};
            ADDR_W'(`FINE_GAIN_TRIM_CORE2_INPUT_B_ADDR): r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE2_INPUT_B};
            ADDR_W'(`FINE_GAIN_TRIM_CORE3_INPUT_C_ADDR): r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE3_INPUT_C};
            ADDR_W'(`FINE_GAIN_TRIM_CORE3_INPUT_D_ADDR): r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE3_INPUT_D};
            ADDR_W'(`FINE_GAIN_TRIM_CORE4_ADDR):         r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE4};
            ADDR_W'(`FINE_GAIN_TRIM_CORE5_ADDR):         r = {1'b1, `IDX_FINE_GAIN_TRIM_CORE5};
            default:                                     r = 5'h00;
        endcase
        return r;
    endfunction : decode

    // Gain slots are 8 bits wide, so their upper byte never holds anything.
    function automatic trim_word_t slot_mask(input trim_idx_t i);
        return (i <= `IDX_OFFSET_TRIM_CORE5) ? `OFS_REG_MASK : `GAIN_REG_MASK;
    endfunction : slot_mask

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    fuse_if      fuse ();
    load_state_t state_r;
    trim_idx_t   load_cnt_r;
    logic        ld_vld_r;
    trim_idx_t   ld_idx_r;
    trim_word_t  trim_r [`NUM_TRIM];
    logic [4:0]  wr_dec;
    logic [4:0]  rd_dec;
    logic        wr_hit;
    logic        rd_hit;
    trim_word_t  wr_word;
    trim_word_t  rd_word;
    logic [3:0]  boot_cnt_r;

    assign wr_dec  = decode(cfg_addr);
    assign rd_dec  = wr_dec;
    assign wr_hit  = cfg_wr && wr_dec[4] && (state_r == RUN);
    assign rd_hit  = cfg_rd && rd_dec[4];
    assign wr_word = cfg_wdata & slot_mask(wr_dec[3:0]);
    assign rd_word = trim_r[rd_dec[3:0]];
    assign load_done = (state_r == RUN);

    // ------------------------------------------------------------------------
    // Fuse default load
    // ------------------------------------------------------------------------
    // One fuse word per cycle; bus writes before RUN are dropped so a load never races them.
    assign fuse.rd_en = (state_r == LOAD);
    assign fuse.addr  = load_cnt_r;

    trim_fuse_store #(
        .FUSE_IMAGE (FUSE_IMAGE)
    ) u_fuse (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .fuse     (fuse.store)
    );

    // Load sequencer walks every slot once after reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= LOAD;
            load_cnt_r <= 4'h0;
        end else begin
            case (state_r)
                LOAD: begin
                    if (load_cnt_r == `IDX_LAST) begin
                        state_r <= LAST;
                    end else begin
                        load_cnt_r <= load_cnt_r + 4'h1;
                    end
                end
                LAST:    state_r <= RUN;
                RUN:     state_r <= RUN;
                default: state_r <= LOAD;
            endcase
        end
    end

    // Tracks which slot the fuse word now on the read port belongs to.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ld_vld_r <= 1'b0;
            ld_idx_r <= 4'h0;
        end else begin
            ld_vld_r <= fuse.rd_en;
            ld_idx_r <= load_cnt_r;
        end
    end

    // ------------------------------------------------------------------------
    // Trim storage
    // ------------------------------------------------------------------------
    // Fuse words first, then software; reserved bits are kept as written, but a gain slot's upper byte is stored as zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `NUM_TRIM; i++) begin
                trim_r[i] <= `TRIM_RESET;
            end
        end else if (ld_vld_r) begin
            trim_r[ld_idx_r] <= fuse.data & slot_mask(ld_idx_r);
        end else if (wr_hit) begin
            trim_r[wr_dec[3:0]] <= wr_word;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Data stand only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= '0;
        end else if (rd_hit) begin
            cfg_rdata <= rd_word;
        end else begin
            cfg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------------------
    // Trims applied to the cores
    // ------------------------------------------------------------------------
    // Select and trim are registered on the same edge so no sample sees a mix.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core2_input_sel_applied <= 1'b0;
            core3_input_sel_applied <= 1'b0;
        end else begin
            core2_input_sel_applied <= core2_input_sel;
            core3_input_sel_applied <= core3_input_sel;
        end
    end

    // Offsets are passed on as unsigned codes, no sign extension anywhere.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_core3 <= 12'h000;
            offset_core4 <= 12'h000;
            offset_core5 <= 12'h000;
        end else begin
            offset_core3 <= core3_input_sel ? trim_r[`IDX_OFFSET_TRIM_CORE3_INPUT_D][`OFS_FIELD_MSB:0]
                                            : trim_r[`IDX_OFFSET_TRIM_CORE3_INPUT_C][`OFS_FIELD_MSB:0];
            offset_core4 <= trim_r[`IDX_OFFSET_TRIM_CORE4][`OFS_FIELD_MSB:0];
            offset_core5 <= trim_r[`IDX_OFFSET_TRIM_CORE5][`OFS_FIELD_MSB:0];
        end
    end

    // Gains use only the low five bits; the reserved three never reach a core.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gain_core0 <= 5'h00;
            gain_core1 <= 5'h00;
            gain_core2 <= 5'h00;
            gain_core3 <= 5'h00;
            gain_core4 <= 5'h00;
            gain_core5 <= 5'h00;
        end else begin
            gain_core0 <= trim_r[`IDX_FINE_GAIN_TRIM_CORE0][`GAIN_FIELD_MSB:0];
            gain_core1 <= trim_r[`IDX_FINE_GAIN_TRIM_CORE1][`GAIN_FIELD_MSB:0];
            gain_core2 <= core2_input_sel ? trim_r[`IDX_FINE_GAIN_TRIM_CORE2_INPUT_B][`GAIN_FIELD_MSB:0]
                                          : trim_r[`IDX_FINE_GAIN_TRIM_CORE2_INPUT_A][`GAIN_FIELD_MSB:0];
            gain_core3 <= core3_input_sel ? trim_r[`IDX_FINE_GAIN_TRIM_CORE3_INPUT_D][`GAIN_FIELD_MSB:0]
                                          : trim_r[`IDX_FINE_GAIN_TRIM_CORE3_INPUT_C][`GAIN_FIELD_MSB:0];
            gain_core4 <= trim_r[`IDX_FINE_GAIN_TRIM_CORE4][`GAIN_FIELD_MSB:0];
            gain_core5 <= trim_r[`IDX_FINE_GAIN_TRIM_CORE5][`GAIN_FIELD_MSB:0];
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Cycles since reset, saturating, for the load timing check.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_r <= 4'h0;
        end else if (boot_cnt_r != 4'hF) begin
            boot_cnt_r <= boot_cnt_r + 4'h1;
        end
    end

    a_load_timing: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(load_done) |-> (boot_cnt_r == 4'(`LOAD_CYCLES)))
        else $error("fuse load did not finish on time");

    a_fuse_word_stored: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ld_vld_r |=> trim_r[$past(ld_idx_r)] == ($past(fuse.data) & slot_mask($past(ld_idx_r))))
        else $error("fuse word not stored in its slot");

    a_write_stored: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit |=> trim_r[$past(wr_dec[3:0])] == $past(wr_word))
        else $error("register write not stored");

    a_read_returns: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit |=> (cfg_rdata == $past(rd_word)) ##1 (cfg_rdata == '0 || $past(cfg_rd)))
        else $error("read data wrong or held too long");

    a_read_unmapped: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_rd && !rd_dec[4]) |=> cfg_rdata == '0)
        else $error("unmapped read gave nonzero data");

    a_offset_core3: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> offset_core3 == ($past(core3_input_sel) ? $past(trim_r[`IDX_OFFSET_TRIM_CORE3_INPUT_D][11:0])
                                                         : $past(trim_r[`IDX_OFFSET_TRIM_CORE3_INPUT_C][11:0])))
        else $error("core 3 offset does not follow input select");

    a_offset_fixed: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit && wr_dec[3:0] == `IDX_OFFSET_TRIM_CORE5 |=> ##1 offset_core5 == $past(cfg_wdata[11:0], 2))
        else $error("core 5 offset not applied after write");

    a_gain_fixed: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit && wr_dec[3:0] == `IDX_FINE_GAIN_TRIM_CORE0 |=> ##1 gain_core0 == $past(cfg_wdata[4:0], 2))
        else $error("core 0 gain not applied after write");

    a_mux_aligned: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $changed(core2_input_sel_applied) |-> gain_core2 == (core2_input_sel_applied
            ? $past(trim_r[`IDX_FINE_GAIN_TRIM_CORE2_INPUT_B][4:0]) : $past(trim_r[`IDX_FINE_GAIN_TRIM_CORE2_INPUT_A][4:0])))
        else $error("core 2 gain not switched with its input");

    a_gain_core3: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $changed(core3_input_sel_applied) |-> gain_core3 == (core3_input_sel_applied
            ? $past(trim_r[`IDX_FINE_GAIN_TRIM_CORE3_INPUT_D][4:0]) : $past(trim_r[`IDX_FINE_GAIN_TRIM_CORE3_INPUT_C][4:0])))
        else $error("core 3 gain not switched with its input");

endmodule : converter_offset_gain_trim_bank
`default_nettype wire

// ---- verification/converter_offset_gain_trim_bank_tb.sv ----
// Self-checking testbench of the converter offset and fine gain trim bank.
`timescale 1ns/1ps
`default_nettype none
`include "trim_bank_regs.svh"
module converter_offset_gain_trim_bank_tb
    import trim_bank_pkg::*;
;
    // ------------------------------------------------------------------------
    // Fuse image, bench signals and the device
    // ------------------------------------------------------------------------
    // Fuse words in slot order; all differ from reset so a missed load shows.
    localparam trim_word_t FW [12] = '{16'h0A11, 16'h0B22, 16'h0C33, 16'h0D44,
        16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008};
    localparam logic [16*`NUM_TRIM-1:0] IMG = {16'h0008, 16'h0007, 16'h0006, 16'h0005,
        16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h0D44, 16'h0C33, 16'h0B22, 16'h0A11};

    typedef struct {
        logic [11:0] addr;
        trim_word_t  wdata;
        trim_word_t  rdexp;
    } row_t;

    // Write a word, read it back, expect the stored image; the last two rows are unmapped and read zero.
    // Reserved bits of every trim register but the core 1 gain (written 16'hAB10) are written as zero, as software must.
    row_t rows [14] = '{
        '{`OFFSET_TRIM_CORE3_INPUT_C_ADDR, 16'h0123, 16'h0123},
        '{`OFFSET_TRIM_CORE3_INPUT_D_ADDR, 16'h0FED, 16'h0FED},
        '{`OFFSET_TRIM_CORE4_ADDR, 16'h0800, 16'h0800},
        '{`OFFSET_TRIM_CORE5_ADDR, 16'h0FFF, 16'h0FFF},
        '{`FINE_GAIN_TRIM_CORE0_ADDR, 16'h001F, 16'h001F},
        '{`FINE_GAIN_TRIM_CORE1_ADDR, 16'hAB10, 16'h0010},
        '{`FINE_GAIN_TRIM_CORE2_INPUT_A_ADDR, 16'h0011, 16'h0011},
        '{`FINE_GAIN_TRIM_CORE2_INPUT_B_ADDR, 16'h0012, 16'h0012},
        '{`FINE_GAIN_TRIM_CORE3_INPUT_C_ADDR, 16'h0013, 16'h0013},
        '{`FINE_GAIN_TRIM_CORE3_INPUT_D_ADDR, 16'h0014, 16'h0014},
        '{`FINE_GAIN_TRIM_CORE4_ADDR, 16'h0015, 16'h0015},
        '{`FINE_GAIN_TRIM_CORE5_ADDR, 16'h0016, 16'h0016},
        '{12'h340, 16'h1234, 16'h0000},
        '{12'h368, 16'h1234, 16'h0000}};

    logic        core_clk;
    logic        rst_n;
    logic [11:0] cfg_addr;
    trim_word_t  cfg_wdata;
    logic        cfg_wr;
    logic        cfg_rd;
    trim_word_t  cfg_rdata;
    logic        core2_input_sel;
    logic        core3_input_sel;
    logic        core2_input_sel_applied;
    logic        core3_input_sel_applied;
    logic [11:0] offset_core3;
    logic [11:0] offset_core4;
    logic [11:0] offset_core5;
    logic [4:0]  gain_core0;
    logic [4:0]  gain_core1;
    logic [4:0]  gain_core2;
    logic [4:0]  gain_core3;
    logic [4:0]  gain_core4;
    logic [4:0]  gain_core5;
    logic        load_done;
    int          n_fail;
    int          tests_run;
    int          n;

    converter_offset_gain_trim_bank #(.FUSE_IMAGE(IMG)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
        .core2_input_sel(core2_input_sel), .core3_input_sel(core3_input_sel),
        .core2_input_sel_applied(core2_input_sel_applied),
        .core3_input_sel_applied(core3_input_sel_applied),
        .offset_core3(offset_core3), .offset_core4(offset_core4),
        .offset_core5(offset_core5), .gain_core0(gain_core0), .gain_core1(gain_core1),
        .gain_core2(gain_core2), .gain_core3(gain_core3), .gain_core4(gain_core4),
        .gain_core5(gain_core5), .load_done(load_done));

    // Free-running 100 MHz clock.
    always #5 core_clk = ~core_clk;

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // One comparison; case inequality so an unknown never passes.
    task automatic chk(input trim_word_t seen, input trim_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One bus cycle, driven right after a rising edge so each signal changes once.
    task automatic bus(input logic wr, input logic rd, input logic [11:0] a, input trim_word_t d);
        @(posedge core_clk);
        cfg_wr    <= wr;
        cfg_rd    <= rd;
        cfg_addr  <= a;
        cfg_wdata <= d;
    endtask : bus

    // Read strobe, then look at the data mid-way through the following cycle.
    task automatic rd_chk(input logic [11:0] a, input trim_word_t exp);
        bus(1'b0, 1'b1, a, 16'h0000);
        bus(1'b0, 1'b0, a, 16'h0000);
        #5;
        chk(cfg_rdata, exp);
    endtask : rd_chk

    // Bounded wait for the fuse load; n returns the edges it took.
    task automatic wait_load();
        n = 0;
        while (load_done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
            #1;
        end
    endtask : wait_load

    // Count report and verdict; the only place the run ends.
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    // A hang counts as a failure; the whole run needs well under 5 us.
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {cfg_wr, cfg_rd, core2_input_sel, core3_input_sel} = 4'h0;
        cfg_addr = 12'h000;
        cfg_wdata = 16'h0000;
        n_fail = 0;
        tests_run = 0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_load();
        chk(16'(n), 16'h000D);
        for (int i = 0; i < 12; i++) rd_chk(rows[i].addr, FW[i]);
        chk(16'(offset_core3), 16'h0A11);
        chk(16'(gain_core3), 16'h0005);
        $display("test fuse defaults done");

        // Each write is followed at once by its read, back to back.
        foreach (rows[i]) begin
            bus(1'b1, 1'b0, rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rdexp);
        end
        $display("test register table done");

        // Walk all select pairs; trims and applied selects move on the same edge.
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            core2_input_sel <= i[0];
            core3_input_sel <= i[1];
            #5;
            // Before the next edge the applied select still shows the previous pass.
            chk(16'(core2_input_sel_applied), (i == 2) ? 16'h0001 : 16'h0000);
            @(posedge core_clk);
            #5;
            chk(16'(core2_input_sel_applied), 16'(i[0]));
            chk(16'(core3_input_sel_applied), 16'(i[1]));
            chk(16'(offset_core3), i[1] ? 16'h0FED : 16'h0123);
            chk(16'(gain_core2), i[0] ? 16'h0012 : 16'h0011);
            chk(16'(gain_core3), i[1] ? 16'h0014 : 16'h0013);
            chk(16'(offset_core4), 16'h0800);
            chk(16'(offset_core5), 16'h0FFF);
            chk({gain_core0, gain_core1}, 16'h03F0);
            chk({gain_core4, gain_core5}, 16'h02B6);
        end
        $display("test input selects done");

        // A write lands on the core two edges after its strobe, and read data stand one cycle.
        bus(1'b1, 1'b0, `OFFSET_TRIM_CORE4_ADDR, 16'h0321);
        bus(1'b0, 1'b1, `OFFSET_TRIM_CORE4_ADDR, 16'h0000);
        #5;
        chk(16'(offset_core4), 16'h0800);
        bus(1'b0, 1'b0, 12'h000, 16'h0000);
        #5;
        chk(16'(offset_core4), 16'h0321);
        chk(cfg_rdata, 16'h0321);
        bus(1'b0, 1'b0, 12'h000, 16'h0000);
        #5;
        chk(cfg_rdata, 16'h0000);
        $display("test write timing done");

        // Reset in mid-run clears the outputs; a write during the reload is lost.
        @(posedge core_clk);
        rst_n <= 1'b0;
        #5;
        chk({4'h0, offset_core5}, 16'h0000);
        chk({11'h000, gain_core0}, 16'h0000);
        chk({15'h0000, load_done}, 16'h0000);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b1, 1'b0, `OFFSET_TRIM_CORE5_ADDR, 16'h0111);
        bus(1'b0, 1'b0, 12'h000, 16'h0000);
        wait_load();
        chk({15'h0000, load_done}, 16'h0001);
        rd_chk(`OFFSET_TRIM_CORE5_ADDR, 16'h0D44);
        rd_chk(`FINE_GAIN_TRIM_CORE0_ADDR, 16'h0001);
        chk(16'(offset_core5), 16'h0D44);
        $display("test reset reload done");
        stop_test();
    end
endmodule : converter_offset_gain_trim_bank_tb
`default_nettype wire
